//--- common/bscx_pkg.sv
package bscx_pkg;

    // Word and field widths of the instruction, the program counter, the file data and the upper-address latch.
    localparam int WORD_W = 14;
    localparam int FADDR_W = 7;
    localparam int BIDX_W = 3;
    localparam int TARGET_W = 11;
    localparam int PC_W = 13;
    localparam int DATA_W = 8;
    localparam int LATCH_W = 8;

    // Field positions inside the instruction word.
    localparam int FADDR_LSB = 0;
    localparam int BIDX_LSB = 7;
    localparam int TARGET_LSB = 0;

    // Bits of the upper-address latch that feed the top counter bits.
    localparam int LATCH_HI = 4;
    localparam int LATCH_LO = 3;

    // Opcode masks and patterns; bits outside a mask are operands, except the accumulator clear's low seven, which are ignored.
    localparam logic [WORD_W-1:0] SKIP_MASK = 14'h3c00;
    localparam logic [WORD_W-1:0] SKIP_CODE = 14'h1c00;
    localparam logic [WORD_W-1:0] ZFILE_MASK = 14'h3f80;
    localparam logic [WORD_W-1:0] ZFILE_CODE = 14'h0180;
    localparam logic [WORD_W-1:0] ZACC_MASK = 14'h3f80;
    localparam logic [WORD_W-1:0] ZACC_CODE = 14'h0100;
    localparam logic [WORD_W-1:0] CALL_MASK = 14'h3800;
    localparam logic [WORD_W-1:0] CALL_CODE = 14'h2000;

    // Constants used by the execute stage.
    localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

    // Execute slot state; the two codes differ in one bit.
    typedef enum logic [1:0] {
        BSCX_RUN = 2'b00,
        BSCX_NOP = 2'b01
    } bscx_state_t;

endpackage

//--- dv/bscx_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none

module bscx_exec_tb
    import bscx_pkg::*;
;
    typedef struct {
        logic [6:0] fl;
        logic [FADDR_W-1:0] wa;
        logic [PC_W-1:0] st;
        logic [PC_W-1:0] pv;
        int cyc;
    } bscx_note_t;

    logic ref_clk;
    logic rst_n;
    logic instr_valid;
    logic [WORD_W-1:0] instr_word;
    logic [PC_W-1:0] instr_pc;
    logic [LATCH_W-1:0] latch;
    logic [DATA_W-1:0] file_rdata;
    logic [FADDR_W-1:0] file_raddr;
    logic file_we;
    logic [FADDR_W-1:0] file_waddr;
    logic [DATA_W-1:0] file_wdata;
    logic acc_clear;
    logic zero_set;
    logic prefetch_discard;
    logic nop_slot;
    logic stack_push;
    logic [PC_W-1:0] stack_top;
    logic pc_load;
    logic [PC_W-1:0] pc_load_value;
    logic [DATA_W-1:0] mem [128];
    logic [6:0] wfl;
    logic drop = 1'b0;
    bscx_note_t notes [$];
    bscx_note_t wn;
    int cyc = 0;
    int fail_count = 0;
    int check_count = 0;

    bscx_exec dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .instr_valid(instr_valid), .instr_word(instr_word),
        .instr_pc(instr_pc), .program_counter_upper_latch(latch),
        .file_rdata(file_rdata), .file_raddr(file_raddr),
        .file_we(file_we), .file_waddr(file_waddr),
        .file_wdata(file_wdata), .acc_clear(acc_clear),
        .zero_set(zero_set), .prefetch_discard(prefetch_discard),
        .nop_slot(nop_slot), .stack_push(stack_push),
        .stack_top(stack_top), .pc_load(pc_load),
        .pc_load_value(pc_load_value));

    // The register file answers in the same cycle, as the core expects.
    assign file_rdata = mem[file_raddr];

    // All pulse outputs in one word, in the order the notes use.
    assign wfl = {file_we, acc_clear, zero_set, prefetch_discard, nop_slot,
                  stack_push, pc_load};

    // Free-running clock and an edge counter used to time every answer.
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) cyc <= cyc + 1;

    task automatic err(input string msg);
        fail_count++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask

    task automatic summarize();
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Presents one word and notes what the core must answer two edges on.
    // A word arriving behind a taken redirect is dropped, so no note.
    task automatic issue(input logic v, input logic [WORD_W-1:0] w,
                         input logic [PC_W-1:0] pc,
                         input logic [LATCH_W-1:0] lt);
        bscx_note_t n;
        @(posedge ref_clk);
        instr_valid <= v;
        instr_word <= w;
        instr_pc <= pc;
        latch <= lt;
        n = '{7'h00, 7'h00, 13'h0000, 13'h0000, cyc};
        if (!v || drop) begin
            drop = 1'b0;
            return;
        end
        if ((w & CALL_MASK) == CALL_CODE) begin
            n.fl = 7'b0001111;
            n.st = pc + PC_STEP;
            n.pv = {lt[LATCH_HI:LATCH_LO], w[TARGET_W-1:0]};
            drop = 1'b1;
        end else if ((w & SKIP_MASK) == SKIP_CODE) begin
            if (mem[w[6:0]][w[9:7]] === 1'b1) begin
                n.fl = 7'b0001100;
                drop = 1'b1;
            end
        end else if ((w & ZFILE_MASK) == ZFILE_CODE) begin
            n.fl = 7'b1010000;
            n.wa = w[FADDR_W-1:0];
        end else if ((w & ZACC_MASK) == ZACC_CODE) begin
            n.fl = 7'b0110000;
        end
        if (n.fl != 7'h00) notes.push_back(n);
    endtask

    // Every pulse must match the oldest note, in content and in time.
    always @(negedge ref_clk) begin
        if (rst_n === 1'b1 && wfl !== 7'h00) begin
            if (notes.size() == 0) begin
                err("output pulse with no pending instruction");
            end else begin
                wn = notes.pop_front();
                check_count++;
                if (wfl !== wn.fl) begin
                    err("pulse set");
                end
                if (cyc != wn.cyc + 3) begin
                    err("pulse timing");
                end
                if (wn.fl[6] && file_waddr !== wn.wa) begin
                    err("clear address");
                end
                if (file_wdata !== ZERO_BYTE) begin
                    err("clear data");
                end
                if (wn.fl[1] && stack_top !== wn.st) begin
                    err("return address");
                end
                if (wn.fl[0] && pc_load_value !== wn.pv) begin
                    err("call target");
                end
            end
        end
    end

    initial begin
        #2000000;
        err("run did not finish in time");
        summarize();
    end

    initial begin
        int i;
        int sel;
        logic [31:0] r;
        logic [WORD_W-1:0] w;
        r = $urandom(72);
        for (i = 0; i < 128; i++) mem[i] = $urandom;
        mem[42] = 8'ha5;
        rst_n = 1'b0;
        instr_valid = 1'b0;
        instr_word = 14'h0000;
        instr_pc = 13'h0000;
        latch = 8'h00;
        repeat (10) @(posedge ref_clk);
        check_count++;
        if (wfl !== 7'h00) begin
            err("pulse during reset");
        end
        rst_n <= 1'b1;
        // Each bit index, taken or not, then a word that may be dropped.
        for (i = 0; i < 8; i++) begin
            w = SKIP_CODE | {4'h0, i[2:0], 7'h2a};
            issue(1'b1, w, 13'h0010, 8'h00);
            issue(1'b1, ZACC_CODE | 14'h007f, 13'h0011, 8'h00);
        end
        // Call boundaries, a call hidden behind a call, clear at edge addresses.
        issue(1'b1, CALL_CODE | 14'h07ff, 13'h1fff, 8'hff);
        issue(1'b1, CALL_CODE, 13'h0000, 8'h10);
        issue(1'b1, CALL_CODE, 13'h0abc, 8'h08);
        issue(1'b1, ZFILE_CODE | 14'h007f, 13'h0001, 8'h00);
        issue(1'b1, ZFILE_CODE | 14'h007f, 13'h0002, 8'h00);
        issue(1'b1, ZFILE_CODE, 13'h0003, 8'h00);
        // Random mix of all four kinds, stray words and idle cycles.
        for (i = 0; i < 600; i++) begin
            sel = $urandom_range(4);
            r = $urandom;
            case (sel)
                0: w = CALL_CODE | {3'h0, r[10:0]};
                1: w = SKIP_CODE | {4'h0, r[9:0]};
                2: w = ZFILE_CODE | {7'h00, r[6:0]};
                3: w = ZACC_CODE | {7'h00, r[6:0]};
                default: w = r[WORD_W-1:0];
            endcase
            r = $urandom;
            sel = $urandom_range(7);
            issue(sel != 0, w, r[PC_W-1:0], r[31:24]);
        end
        issue(1'b0, 14'h0000, 13'h0000, 8'h00);
        for (i = 0; i < 20 && notes.size() != 0; i++) @(posedge ref_clk);
        if (notes.size() != 0) err("expected pulses never came");
        summarize();
    end
endmodule

`default_nettype wire

//--- logic/bscx_decode.sv
`timescale 1ns/1ps
`default_nettype none

module bscx_decode
    import bscx_pkg::*;
(
    input wire logic [WORD_W-1:0] word,
    output logic is_skip,
    output logic is_zero_file,
    output logic is_zero_acc,
    output logic is_call,
    output logic [BIDX_W-1:0] bit_idx,
    output logic [FADDR_W-1:0] faddr,
    output logic [TARGET_W-1:0] target
);

    // Pure pattern match; the accumulator clear ignores its low seven bits.
    assign is_skip = (word & SKIP_MASK) == SKIP_CODE;
    assign is_zero_file = (word & ZFILE_MASK) == ZFILE_CODE;
    assign is_zero_acc = (word & ZACC_MASK) == ZACC_CODE;
    assign is_call = (word & CALL_MASK) == CALL_CODE;

    // Operand fields, valid only alongside the matching opcode flag.
    assign bit_idx = word[BIDX_LSB +: BIDX_W];
    assign faddr = word[FADDR_LSB +: FADDR_W];
    assign target = word[TARGET_LSB +: TARGET_W];

endmodule

`default_nettype wire

//--- logic/bscx_exec.sv
// Behaviour
// - Bit-test skip: 3-bit index, 7-bit address, status flags untouched.
// - A set tested bit discards the prefetched word and runs a no-op.
// - The bit-test skip takes one cycle, or two when it skips.
// - File clear zeroes its register, sets the zero flag, in one cycle.
// - Acc clear zeroes it, sets zero, one cycle, low 7 bits ignored.
// - A call pushes counter plus one onto the stack top, in the same cycle as the load.
// - A call loads the 11-bit target low and latch bits 4:3 on top.
// - A call has a 3-bit prefix, a target up to 2047, and two cycles.
`timescale 1ns/1ps
`default_nettype none

module bscx_exec
    import bscx_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [WORD_W-1:0] instr_word,
    input wire logic [PC_W-1:0] instr_pc,
    input wire logic [LATCH_W-1:0] program_counter_upper_latch,
    input wire logic [DATA_W-1:0] file_rdata,
    output logic [FADDR_W-1:0] file_raddr,
    output logic file_we,
    output logic [FADDR_W-1:0] file_waddr,
    output logic [DATA_W-1:0] file_wdata,
    output logic acc_clear,
    output logic zero_set,
    output logic prefetch_discard,
    output logic nop_slot,
    output logic stack_push,
    output logic [PC_W-1:0] stack_top,
    output logic pc_load,
    output logic [PC_W-1:0] pc_load_value
);

    // Execute-stage holding registers.
    logic ex_valid_r;
    logic [WORD_W-1:0] ex_word_r;
    logic [PC_W-1:0] ex_pc_r;
    logic [LATCH_W-1:0] ex_latch_r;
    bscx_state_t st_r;
    bscx_state_t st_nxt;

    // Output registers.
    logic file_we_r;
    logic [FADDR_W-1:0] file_waddr_r;
    logic [DATA_W-1:0] file_wdata_r;
    logic acc_clear_r;
    logic zero_set_r;
    logic discard_r;
    logic push_r;
    logic [PC_W-1:0] push_data_r;
    logic pc_load_r;
    logic [PC_W-1:0] pc_value_r;
    logic nop_r;

    // Decoded view of the word in execute.
    logic is_skip;
    logic is_zero_file;
    logic is_zero_acc;
    logic is_call;
    logic [BIDX_W-1:0] bit_idx;
    logic [FADDR_W-1:0] faddr;
    logic [TARGET_W-1:0] target;
    logic do_skip;
    logic do_call;
    logic redirect;

    bscx_decode u_decode (
        .word(ex_word_r),
        .is_skip(is_skip),
        .is_zero_file(is_zero_file),
        .is_zero_acc(is_zero_acc),
        .is_call(is_call),
        .bit_idx(bit_idx),
        .faddr(faddr),
        .target(target)
    );

    // The register file answers the read address in the same cycle, so
    // the tested bit is known while the instruction sits in execute.
    assign do_skip = ex_valid_r && is_skip && file_rdata[bit_idx];
    assign do_call = ex_valid_r && is_call;
    assign redirect = do_skip || do_call;

    // A taken skip or a call costs one extra slot; nothing else does.
    // The no-operation slot never redirects, because the dropped word left
    // execute empty; unused codes fall back to the run state.
    always_comb begin
        st_nxt = BSCX_RUN;
        unique case (st_r)
            BSCX_RUN: begin
                if (redirect) begin
                    st_nxt = BSCX_NOP;
                end
            end
            BSCX_NOP: begin
                st_nxt = BSCX_RUN;
            end
            default: begin
                st_nxt = BSCX_RUN;
            end
        endcase
    end

    // The slot flag is its own flop so the port carries no state decode.

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= BSCX_RUN;
            nop_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            nop_r <= (st_nxt == BSCX_NOP);
        end
    end

    // Fetch hand-off into execute. The word prefetched behind a redirect
    // is dropped here, so the following slot executes as a no-operation.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ex_valid_r <= 1'b0;
            ex_word_r <= '0;
            ex_pc_r <= '0;
            ex_latch_r <= '0;
        end else begin
            ex_valid_r <= instr_valid && !redirect;
            ex_word_r <= instr_word;
            ex_pc_r <= instr_pc;
            ex_latch_r <= program_counter_upper_latch;
        end
    end

    // Register-file and accumulator side effects of the two clears. The
    // skip never reaches zero_set, which keeps the status flags intact.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            file_we_r <= 1'b0;
            file_waddr_r <= '0;
            file_wdata_r <= ZERO_BYTE;
            acc_clear_r <= 1'b0;
            zero_set_r <= 1'b0;
        end else begin
            file_we_r <= ex_valid_r && is_zero_file;
            file_waddr_r <= faddr;
            file_wdata_r <= ZERO_BYTE;
            acc_clear_r <= ex_valid_r && is_zero_acc;
            zero_set_r <= ex_valid_r && (is_zero_file || is_zero_acc);
        end
    end

    // Flow control: discard pulse, stack push and program-counter load.
    // Push data uses the pre-load counter, so push and load pulse in the same cycle.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            discard_r <= 1'b0;
            push_r <= 1'b0;
            push_data_r <= '0;
            pc_load_r <= 1'b0;
            pc_value_r <= '0;
        end else begin
            discard_r <= redirect;
            push_r <= do_call;
            push_data_r <= ex_pc_r + PC_STEP;
            pc_load_r <= do_call;
            pc_value_r <= {ex_latch_r[LATCH_HI:LATCH_LO], target};
        end
    end

    // Ports are taken straight from the registers above.
    assign file_raddr = ex_word_r[FADDR_LSB +: FADDR_W];
    assign file_we = file_we_r;
    assign file_waddr = file_waddr_r;
    assign file_wdata = file_wdata_r;
    assign acc_clear = acc_clear_r;
    assign zero_set = zero_set_r;
    assign prefetch_discard = discard_r;
    assign nop_slot = nop_r;
    assign stack_push = push_r;
    assign stack_top = push_data_r;
    assign pc_load = pc_load_r;
    assign pc_load_value = pc_value_r;

    // All checks below run on the core clock and rest during reset.
    default clocking cb_core @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // Two-slot shape of a redirect: a no-operation slot, then normal run.
    sequence s_nop_then_run;
        (nop_slot && !ex_valid_r) ##1 !nop_slot;
    endsequence

    a_skip_no_status: assert property (
        (ex_valid_r && is_skip) |=> !zero_set && !file_we && !acc_clear)
        else $error("bit-test skip touched status or data");

    a_skip_discard: assert property (
        do_skip |=> prefetch_discard && !stack_push && !pc_load)
        else $error("taken skip did not discard the prefetch");

    a_skip_two_slot: assert property (
        do_skip |=> s_nop_then_run)
        else $error("taken skip did not take two slots");

    a_skip_one_slot: assert property (
        (ex_valid_r && is_skip && !file_rdata[bit_idx])
        |=> !nop_slot && !prefetch_discard)
        else $error("untaken skip stalled");

    a_clear_file: assert property (
        (ex_valid_r && is_zero_file) |=> file_we && zero_set
        && file_wdata == ZERO_BYTE
        && file_waddr == $past(ex_word_r[FADDR_LSB +: FADDR_W]))
        else $error("file clear wrong");

    a_clear_acc: assert property (
        (ex_valid_r
        && ex_word_r[WORD_W-1:FADDR_W] == ZACC_CODE[WORD_W-1:FADDR_W])
        |=> acc_clear && zero_set && !file_we && !nop_slot)
        else $error("accumulator clear wrong");

    a_call_push: assert property (
        do_call |=> stack_push && stack_top == $past(ex_pc_r) + PC_STEP)
        else $error("call pushed wrong return address");

    a_call_target: assert property (
        do_call |=> pc_load
        && pc_load_value[TARGET_W-1:0] == $past(ex_word_r[TARGET_W-1:0])
        && pc_load_value[PC_W-1:TARGET_W]
        == $past(ex_latch_r[LATCH_HI:LATCH_LO]))
        else $error("call loaded wrong counter value");

    a_call_two_slot: assert property (
        do_call |=> s_nop_then_run)
        else $error("call did not take two slots");

    a_call_flush: assert property (
        (ex_valid_r
        && ex_word_r[WORD_W-1:TARGET_W] == CALL_CODE[WORD_W-1:TARGET_W])
        |=> prefetch_discard && !zero_set)
        else $error("call did not flush the prefetch");

endmodule

`default_nettype wire
